// File: rtl/flbp_pkg.sv
// flbp_pkg: constants and types of the lock-bit host controller
package flbp_pkg;
   // clock and flash pin timing
   localparam int unsigned CLK_MHZ       = 250;
   localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
   localparam int unsigned T_WE_LOW_NS   = 50;
   localparam int unsigned T_WE_HIGH_NS  = 30;
   localparam int unsigned T_READ_NS     = 120;
   // least times round up to whole cycles
   localparam int unsigned C_WE_LOW  =
      (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned C_WE_HIGH =
      (T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned C_READ    =
      (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // register map, byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;

   // control register fields
   localparam int unsigned CTRL_OP_LSB = 0;
   localparam int unsigned CTRL_OP_W   = 3;
   localparam int unsigned CTRL_OVR    = 3;
   localparam int unsigned CTRL_RST    = 4;
   localparam int unsigned CTRL_AUTO   = 5;

   // status register fields
   localparam int unsigned STAT_BUSY   = 8;
   localparam int unsigned STAT_DONE   = 9;
   localparam int unsigned STAT_ERR    = 10;
   localparam int unsigned STAT_REPEAT = 11;
   localparam int unsigned STAT_RB     = 12;

   // bits of the device's own status byte
   localparam int unsigned MACHINE_READY_BIT          = 7;
   localparam int unsigned ERASE_CLEAR_LOCK_ERROR_BIT = 5;
   localparam int unsigned PROGRAM_SET_LOCK_ERROR_BIT = 4;
   localparam int unsigned PROGRAM_SUPPLY_LOW_BIT     = 3;
   localparam int unsigned DEVICE_PROTECT_BIT         = 1;

   localparam int unsigned FLASH_ADDR_W = 21;
   localparam logic [7:0]  CMD_CLEAR_STATUS = 8'h50;

   typedef enum logic [2:0] {
      OP_NONE, OP_SET_BLOCK, OP_SET_MASTER, OP_CLEAR_LOCKS,
      OP_CLEAR_STATUS
   } flbp_op_t;

   typedef struct packed {
      logic                    chip_en_n;
      logic                    write_en_n;
      logic                    read_en_n;
      logic [FLASH_ADDR_W-1:0] addr;
      logic [7:0]              dout;
      logic                    dout_en_n;
   } flbp_pins_t;
endpackage : flbp_pkg

// File: rtl/flbp_host.sv
// flbp_host: host sequencer for flash lock-bit commands, APB controlled
// Overview of operation
// - lock set is setup write then confirm write
// - host checks set-lock error, clears status
// - clear locks is setup then confirm write
// - host checks clear-lock error, clears status
// - aborted clear must be repeated by host
`timescale 1ns/100ps
`default_nettype none

module flbp_host #(
   parameter logic [7:0]  CMD_LOCK_SETUP    = 8'h60,
   parameter logic [7:0]  CMD_BLOCK_CONFIRM = 8'h01,
   parameter logic [7:0]  CMD_MASTER_CONFIRM = 8'hF1,
   parameter logic [7:0]  CMD_CLEAR_CONFIRM = 8'hD0,
   parameter int unsigned T_SETTLE_NS       = 100
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   output flbp_pkg::flbp_pins_t     pins,
   input  wire logic [7:0]          data_in,
   input  wire logic                ready_busy_pin,
   output logic                     reset_powerdown_n,
   output logic                     override_high_level
);
   localparam int unsigned C_SETTLE =
      (T_SETTLE_NS + flbp_pkg::CLK_PERIOD_NS - 1) / flbp_pkg::CLK_PERIOD_NS;

   if (C_SETTLE < 1 || C_SETTLE > 255 || flbp_pkg::C_READ > 255 ||
       CMD_LOCK_SETUP == CMD_CLEAR_CONFIRM) begin : g_bad
      $error("flbp_host: timing or command parameters out of range");
   end

   typedef enum logic [3:0] {
      S_IDLE, S_W1_LO, S_W1_HI, S_W2_LO, S_W2_HI, S_SETTLE, S_POLL, S_READ
   } flbp_state_t;

   flbp_state_t                         state;
   flbp_pkg::flbp_op_t                  op_cur;
   logic [7:0]                          cnt;
   logic                                single;
   logic [flbp_pkg::FLASH_ADDR_W-1:0]   addr_reg;
   logic                                ctrl_ovr;
   logic                                ctrl_rst;
   logic                                ctrl_auto;
   logic [7:0]                          status_byte;
   logic                                done;
   logic                                err;
   logic                                repeat_needed;
   logic                                rb_s1;
   logic                                rb_s2;
   logic [7:0]                          din_s1;
   logic [7:0]                          din_s2;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rb_s1  <= 1'b0;
         rb_s2  <= 1'b0;
         din_s1 <= 8'h00;
         din_s2 <= 8'h00;
      end else begin
         rb_s1  <= ready_busy_pin;
         rb_s2  <= rb_s1;
         din_s1 <= data_in;
         din_s2 <= din_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   wire                 busy      = (state != S_IDLE);
   wire                 acc       = psel & penable;
   wire                 hit_ctrl  = (paddr == flbp_pkg::REG_CTRL);
   wire                 hit_addr  = (paddr == flbp_pkg::REG_ADDR);
   wire                 hit_stat  = (paddr == flbp_pkg::REG_STAT);
   wire                 unmapped  = ~(hit_ctrl | hit_addr | hit_stat);
   wire flbp_pkg::flbp_op_t wr_op = flbp_pkg::flbp_op_t'(
      pwdata[flbp_pkg::CTRL_OP_LSB +: flbp_pkg::CTRL_OP_W]);
   wire                 bad_op    = (wr_op > flbp_pkg::OP_CLEAR_STATUS);
   wire                 want_op   = (wr_op != flbp_pkg::OP_NONE);
   // a new command while one runs is refused, not queued
   wire                 refuse    = pwrite & hit_ctrl & want_op &
                                    (busy | bad_op);
   wire                 wr_ok     = acc & pwrite & ~unmapped & ~refuse;
   wire                 start     = wr_ok & hit_ctrl & want_op &
                                    ~pwdata[flbp_pkg::CTRL_RST];
   // taking the device into reset mid-operation abandons it
   wire                 abort     = busy & ctrl_rst;

   assign pready  = 1'b1;
   assign pslverr = acc & (unmapped | refuse);

   wire [31:0] rd_ctrl = 32'({ctrl_auto, ctrl_rst, ctrl_ovr, 3'h0});
   wire [31:0] rd_stat = 32'({rb_s2, repeat_needed, err, done, busy,
                              status_byte});
   wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                         hit_addr ? 32'(addr_reg) :
                         hit_stat ? rd_stat : 32'h0000_0000;

   // confirm byte of the running sequence
   wire [7:0] conf_code =
      (op_cur == flbp_pkg::OP_SET_MASTER)  ? CMD_MASTER_CONFIRM :
      (op_cur == flbp_pkg::OP_CLEAR_LOCKS) ? CMD_CLEAR_CONFIRM :
                                             CMD_BLOCK_CONFIRM;
   // error bit that answers for the running operation
   wire err_now =
      (op_cur == flbp_pkg::OP_CLEAR_LOCKS) ?
         din_s2[flbp_pkg::ERASE_CLEAR_LOCK_ERROR_BIT] :
         din_s2[flbp_pkg::PROGRAM_SET_LOCK_ERROR_BIT];
   wire tick = (cnt == 8'h00);

   assign reset_powerdown_n   = ~ctrl_rst;
   assign override_high_level = ctrl_ovr & ~ctrl_rst;

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata    <= 32'h0000_0000;
         addr_reg  <= '0;
         ctrl_ovr  <= 1'b0;
         ctrl_rst  <= 1'b0;
         ctrl_auto <= 1'b0;
      end else begin
         if (psel & ~penable & ~pwrite)
            prdata <= rd_mux;
         if (wr_ok & hit_addr)
            addr_reg <= pwdata[flbp_pkg::FLASH_ADDR_W-1:0];
         if (wr_ok & hit_ctrl) begin
            ctrl_ovr  <= pwdata[flbp_pkg::CTRL_OVR];
            ctrl_rst  <= pwdata[flbp_pkg::CTRL_RST];
            ctrl_auto <= pwdata[flbp_pkg::CTRL_AUTO];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state         <= S_IDLE;
         op_cur        <= flbp_pkg::OP_NONE;
         cnt           <= 8'h00;
         single        <= 1'b0;
         pins          <= '{chip_en_n: 1'b1, write_en_n: 1'b1,
                            read_en_n: 1'b1, addr: '0, dout: 8'h00,
                            dout_en_n: 1'b1};
         status_byte   <= 8'h00;
         done          <= 1'b0;
         err           <= 1'b0;
         repeat_needed <= 1'b0;
      end else if (abort) begin
         // lock bits stay unknown until a clear runs to its end
         state           <= S_IDLE;
         pins.chip_en_n  <= 1'b1;
         pins.write_en_n <= 1'b1;
         pins.read_en_n  <= 1'b1;
         pins.dout_en_n  <= 1'b1;
      end else begin
         if (!tick)
            cnt <= cnt - 8'h01;
         case (state)
            S_IDLE: begin
               if (start) begin
                  op_cur          <= wr_op;
                  done            <= 1'b0;
                  err             <= 1'b0;
                  single          <= (wr_op == flbp_pkg::OP_CLEAR_STATUS);
                  pins.addr       <= addr_reg;
                  pins.dout       <= (wr_op == flbp_pkg::OP_CLEAR_STATUS) ?
                                     flbp_pkg::CMD_CLEAR_STATUS :
                                     CMD_LOCK_SETUP;
                  pins.chip_en_n  <= 1'b0;
                  pins.write_en_n <= 1'b0;
                  pins.dout_en_n  <= 1'b0;
                  cnt             <= 8'(flbp_pkg::C_WE_LOW - 1);
                  state <= (wr_op == flbp_pkg::OP_CLEAR_STATUS) ?
                           S_W2_LO : S_W1_LO;
                  if (wr_op == flbp_pkg::OP_CLEAR_LOCKS)
                     repeat_needed <= 1'b1;
               end
            end
            S_W1_LO, S_W2_LO: begin
               if (tick) begin
                  pins.write_en_n <= 1'b1;
                  cnt   <= 8'(flbp_pkg::C_WE_HIGH - 1);
                  state <= (state == S_W1_LO) ? S_W1_HI : S_W2_HI;
               end
            end
            S_W1_HI: begin
               if (tick) begin
                  pins.dout       <= conf_code;
                  pins.write_en_n <= 1'b0;
                  cnt   <= 8'(flbp_pkg::C_WE_LOW - 1);
                  state <= S_W2_LO;
               end
            end
            S_W2_HI: begin
               if (tick) begin
                  pins.dout_en_n <= 1'b1;
                  pins.chip_en_n <= 1'b1;
                  if (single) begin
                     done  <= 1'b1;
                     state <= S_IDLE;
                  end else begin
                     // give the device time to pull its ready pin low
                     cnt   <= 8'(C_SETTLE - 1);
                     state <= S_SETTLE;
                  end
               end
            end
            S_SETTLE: begin
               if (tick)
                  state <= S_POLL;
            end
            S_POLL: begin
               if (rb_s2) begin
                  pins.chip_en_n <= 1'b0;
                  pins.read_en_n <= 1'b0;
                  cnt   <= 8'(flbp_pkg::C_READ - 1);
                  state <= S_READ;
               end
            end
            S_READ: begin
               if (tick) begin
                  status_byte    <= din_s2;
                  err            <= err_now;
                  pins.read_en_n <= 1'b1;
                  if (op_cur == flbp_pkg::OP_CLEAR_LOCKS && !err_now)
                     repeat_needed <= 1'b0;
                  if (err_now && ctrl_auto) begin
                     // error seen: wipe the status byte before reporting
                     single          <= 1'b1;
                     pins.dout       <= flbp_pkg::CMD_CLEAR_STATUS;
                     pins.write_en_n <= 1'b0;
                     pins.dout_en_n  <= 1'b0;
                     cnt   <= 8'(flbp_pkg::C_WE_LOW - 1);
                     state <= S_W2_LO;
                  end else begin
                     pins.chip_en_n <= 1'b1;
                     done  <= 1'b1;
                     state <= S_IDLE;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic       we_q;
   logic [1:0] wr_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         we_q   <= 1'b1;
         wr_cnt <= 2'h0;
      end else begin
         we_q <= pins.write_en_n;
         if (state == S_IDLE)
            wr_cnt <= 2'h0;
         else if (we_q && !pins.write_en_n && wr_cnt != 2'h3)
            wr_cnt <= wr_cnt + 2'h1;
      end
   end

   property p_two_writes;
      $rose(state == S_SETTLE) |-> wr_cnt == 2'h2;
   endproperty
   a_two_writes: assert property (p_two_writes)
      else $error("lock sequence did not issue exactly two writes");

   property p_drive_on_write;
      !pins.write_en_n |-> !pins.dout_en_n && !pins.chip_en_n;
   endproperty
   a_drive_on_write: assert property (p_drive_on_write)
      else $error("write strobe without data drive");

   property p_clear_confirm;
      (state == S_W1_HI && op_cur == flbp_pkg::OP_CLEAR_LOCKS && tick &&
       !abort)
      |=> pins.dout == CMD_CLEAR_CONFIRM && !pins.write_en_n;
   endproperty
   a_clear_confirm: assert property (p_clear_confirm)
      else $error("clear locks confirm byte wrong");

   property p_set_err_clear;
      (state == S_READ && tick && op_cur != flbp_pkg::OP_CLEAR_LOCKS &&
       din_s2[flbp_pkg::PROGRAM_SET_LOCK_ERROR_BIT] && ctrl_auto && !abort)
      |=> state == S_W2_LO && pins.dout == flbp_pkg::CMD_CLEAR_STATUS;
   endproperty
   a_set_err_clear: assert property (p_set_err_clear)
      else $error("set-lock error not followed by status clear");

   property p_clr_err_clear;
      (state == S_READ && tick && op_cur == flbp_pkg::OP_CLEAR_LOCKS &&
       din_s2[flbp_pkg::ERASE_CLEAR_LOCK_ERROR_BIT] && ctrl_auto && !abort)
      |=> state == S_W2_LO ##[1:40] state == S_IDLE;
   endproperty
   a_clr_err_clear: assert property (p_clr_err_clear)
      else $error("clear-lock error not followed by status clear");

   property p_abort_repeat;
      (abort && op_cur == flbp_pkg::OP_CLEAR_LOCKS)
      |=> repeat_needed && state == S_IDLE;
   endproperty
   a_abort_repeat: assert property (p_abort_repeat)
      else $error("aborted clear did not flag repeat");

   c_block_lock: cover property (state == S_READ && tick &&
                                 op_cur == flbp_pkg::OP_SET_BLOCK);
   c_clear_locks: cover property (state == S_READ && tick &&
                                  op_cur == flbp_pkg::OP_CLEAR_LOCKS);
   c_auto_clear: cover property (state == S_READ && tick && err_now &&
                                 ctrl_auto);
   c_abort: cover property (abort);
endmodule : flbp_host

`default_nettype wire

// File: testbench/flbp_flash_model.sv
// flbp_flash_model: behavioural flash device answering lock-bit commands
`timescale 1ns/100ps
`default_nettype none

module flbp_flash_model #(
   parameter int BUSY_CYC = 40
) (
   input  wire logic                 pclk,
   input  wire flbp_pkg::flbp_pins_t pins,
   input  wire logic                 reset_powerdown_n,
   input  wire logic                 override_high_level,
   input  wire logic                 supply_low,
   output logic [7:0]                data_in,
   output logic                      ready_busy_pin
);
   // no path ever clears master_lock
   logic [31:0] block_lock = 32'h0000_0000;
   logic        master_lock = 1'b0;
   logic [6:0]  err_bits = 7'h00;
   logic        setup_seen = 1'b0;
   logic        prog_seen = 1'b0;
   logic        we_q = 1'b1;
   logic        clr_run = 1'b0;
   logic [7:0]  last_out = 8'h00;
   int          busy_cnt = 0;
   wire logic   reading;
   wire logic   we_rise;
   wire logic   ovr;

   assign reading = !pins.chip_en_n && !pins.read_en_n;
   assign we_rise = !we_q && pins.write_en_n && !pins.chip_en_n;
   assign ovr     = override_high_level;
   // bus not driven by the device toggles, so stale data never matches
   assign data_in = reading ? {busy_cnt == 0, err_bits} : ~last_out;
   assign ready_busy_pin = (busy_cnt == 0);

   ////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      we_q     <= pins.write_en_n;
      last_out <= data_in;
      if (!reset_powerdown_n) begin
         setup_seen <= 1'b0;
         prog_seen  <= 1'b0;
         busy_cnt   <= 0;
         err_bits   <= 7'h00;
         // an aborted clear leaves the lock bits undefined
         if (clr_run) begin
            block_lock <= 32'hA5A5_5A5A;
         end
         clr_run <= 1'b0;
      end else begin
         if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
         end
         if (busy_cnt == 1 && clr_run) begin
            block_lock <= 32'h0000_0000;
            clr_run    <= 1'b0;
         end
         if (we_rise && setup_seen) begin
            setup_seen <= 1'b0;
            busy_cnt   <= BUSY_CYC;
            case (pins.dout)
               8'h01: if (master_lock && !ovr) err_bits <= err_bits | 7'h12;
                      else block_lock[pins.addr[20:16]] <= 1'b1;
               8'hF1: if (!ovr) err_bits <= err_bits | 7'h12;
                      else master_lock <= 1'b1;
               8'hD0: if (supply_low) err_bits <= err_bits | 7'h28;
                      else if (master_lock && !ovr) err_bits <= err_bits | 7'h22;
                      else clr_run <= 1'b1;
               default: err_bits <= err_bits | 7'h30;
            endcase
         end else if (we_rise && prog_seen) begin
            prog_seen <= 1'b0;
            // a locked block refuses the byte unless overridden
            if (block_lock[pins.addr[20:16]] && !ovr)
               err_bits <= err_bits | 7'h12;
         end else if (we_rise && pins.dout == 8'h40) begin
            prog_seen <= 1'b1;
         end else if (we_rise && pins.dout == 8'h60) begin
            setup_seen <= 1'b1;
         end else if (we_rise && pins.dout == 8'h50) begin
            err_bits <= 7'h00;
         end
      end
   end
endmodule : flbp_flash_model
`default_nettype wire

// File: testbench/flbp_host_tb.sv
// flbp_host_tb: directed tests of the lock-bit host against a flash model
`timescale 1ns/100ps
`default_nettype none

module flbp_host_tb;
   logic                 pclk = 1'b0;
   logic                 presetn;
   logic                 psel;
   logic                 penable;
   logic                 pwrite;
   logic [7:0]           paddr;
   logic [31:0]          pwdata;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   flbp_pkg::flbp_pins_t pins;
   logic [7:0]           data_in;
   logic                 ready_busy_pin;
   logic                 reset_powerdown_n;
   logic                 override_high_level;
   logic                 supply_low;
   int                   fails = 0;
   int                   checks_done = 0;
   int                   cycles = 0;
   logic [31:0]          rd;
   logic                 rerr;
   logic                 auto_mode = 1'b0;

   always #2 pclk = ~pclk;

   flbp_host #(.T_SETTLE_NS(4)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pins(pins), .data_in(data_in), .ready_busy_pin(ready_busy_pin),
      .reset_powerdown_n(reset_powerdown_n),
      .override_high_level(override_high_level));

   flbp_flash_model u_flash (.pclk(pclk), .pins(pins),
      .reset_powerdown_n(reset_powerdown_n),
      .override_high_level(override_high_level), .supply_low(supply_low),
      .data_in(data_in), .ready_busy_pin(ready_busy_pin));

   ////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic run_op(input logic [2:0] op, input logic ovr,
                         input logic [20:0] fa, input logic [7:0] exp_sr);
      logic [31:0] r;
      logic        e;
      int          n;
      r = 32'h0;
      n = 0;
      apb(1'b1, flbp_pkg::REG_ADDR, {11'h000, fa}, r, e);
      apb(1'b1, flbp_pkg::REG_CTRL, {26'h0, auto_mode, 1'b0, ovr, op}, r, e);
      // a write returns the last read word, which must not end the poll
      r = 32'h0;
      while (r[flbp_pkg::STAT_DONE] !== 1'b1 && n < 400) begin
         apb(1'b0, flbp_pkg::REG_STAT, 32'h0, r, e);
         n++;
      end
      check("done", 32'h1, 32'(r[flbp_pkg::STAT_DONE]));
      if (op != 3'h4) begin
         check("status byte", 32'(exp_sr), 32'(r[7:0]));
         check("err", 32'(op == 3'h3 ? exp_sr[5] : exp_sr[4]),
               32'(r[flbp_pkg::STAT_ERR]));
      end
   endtask : run_op

   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   // hang guard, well above the fewer than 2000 cycles the tests need
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails++;
         results();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      presetn    = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 8'h00;
      pwdata     = 32'h0;
      supply_low = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // the ready pin needs two clocks to cross the synchroniser
      repeat (2) @(posedge pclk);
      apb(1'b0, flbp_pkg::REG_STAT, 32'h0, rd, rerr);
      check("stat reset", 32'h0000_1000, rd);
      apb(1'b0, 8'h0C, 32'h0, rd, rerr);
      check("unmapped slverr", 32'h1, 32'(rerr));
      apb(1'b1, flbp_pkg::REG_CTRL, 32'h0000_0007, rd, rerr);
      check("bad op slverr", 32'h1, 32'(rerr));
      $display("test reset done");
      run_op(3'h1, 1'b0, 21'h02_0000, 8'h80);
      run_op(3'h2, 1'b0, 21'h00_0000, 8'h92);
      run_op(3'h1, 1'b0, 21'h01_0000, 8'h92);
      run_op(3'h4, 1'b0, 21'h00_0000, 8'h00);
      check("master after refusal", 32'h0, 32'(u_flash.master_lock));
      run_op(3'h2, 1'b1, 21'h00_0000, 8'h80);
      $display("test set locks done");
      run_op(3'h1, 1'b0, 21'h03_0000, 8'h92);
      run_op(3'h4, 1'b0, 21'h00_0000, 8'h00);
      run_op(3'h1, 1'b1, 21'h03_0000, 8'h80);
      check("block locks", 32'h0000_000E, u_flash.block_lock);
      run_op(3'h3, 1'b0, 21'h00_0000, 8'hA2);
      run_op(3'h4, 1'b0, 21'h00_0000, 8'h00);
      supply_low <= 1'b1;
      run_op(3'h3, 1'b1, 21'h00_0000, 8'hA8);
      check("locks kept", 32'h0000_000E, u_flash.block_lock);
      run_op(3'h4, 1'b0, 21'h00_0000, 8'h00);
      supply_low <= 1'b0;
      run_op(3'h3, 1'b1, 21'h00_0000, 8'h80);
      check("locks cleared", 32'h0, u_flash.block_lock);
      check("master kept", 32'h1, 32'(u_flash.master_lock));
      $display("test clear locks done");
      auto_mode = 1'b1;
      run_op(3'h2, 1'b0, 21'h00_0000, 8'h92);
      check("auto clear set", 32'h0, 32'(u_flash.err_bits));
      run_op(3'h3, 1'b0, 21'h00_0000, 8'hA2);
      check("auto clear locks", 32'h0, 32'(u_flash.err_bits));
      auto_mode = 1'b0;
      $display("test auto clear done");
      apb(1'b1, flbp_pkg::REG_CTRL, 32'h0000_000B, rd, rerr);
      repeat (50) @(posedge pclk);
      apb(1'b1, flbp_pkg::REG_CTRL, 32'h0000_0010, rd, rerr);
      apb(1'b0, flbp_pkg::REG_STAT, 32'h0, rd, rerr);
      check("abort flags", 32'h0000_0800, rd & 32'h0000_0F00);
      apb(1'b1, flbp_pkg::REG_CTRL, 32'h0000_0000, rd, rerr);
      repeat (4) @(posedge pclk);
      run_op(3'h3, 1'b1, 21'h00_0000, 8'h80);
      apb(1'b0, flbp_pkg::REG_STAT, 32'h0, rd, rerr);
      check("repeat cleared", 32'h0, 32'(rd[flbp_pkg::STAT_REPEAT]));
      check("locks known", 32'h0, u_flash.block_lock);
      $display("test abort done");
      results();
   end
endmodule : flbp_host_tb
`default_nettype wire
